//--- rtl/nvmc_pkg.sv
// Operation
// R01 - bank zero decodes at 0x60000000, bank one directly after at 0x60040000
// R02 - programming and start-up initialisation run from the 25 MHz oscillator pace
// R03 - reads and verifies run on the subsystem bus clock
// R04 - array reads insert wait states set by the read wait range
// R05 - SECDED on every 64-bit word, check bits outside user array, always on
// R06 - read line buffer of four 64-bit words acting as a small cache
// R07 - wrapping burst read launches four array reads, beats return when ready
// R08 - buffered word returns at once; a miss starts a timed 64-bit access; code returns a buffered word at once only in ST_IDLE, else stalls until idle
// R09 - assembly buffer holds one 1,024-bit page; one page per operation
// R10 - assembly buffer updates are blocked while programming runs
// R11 - master issues a separate page sequence for every page it writes
// R12 - 32-word staging buffer can be refilled while the array programs
// R13 - sectors of 32 pages, each page 128 bytes as sixteen 64-bit locations
// R14 - programming still allowed past count threshold; status flag reports it
// R15 - 32-bit bus words converted to and from 64-bit array words
// R16 - assembly buffer is readable from the bus
// R17 - bus writes to the user array get an error and change nothing
// R18 - staging buffer takes byte, half-word and word writes
// R19 - assembly buffer loads directly or from staging; programming uses its contents
// R20 - programming always covers a whole page aligned to a page boundary
// R21 - staged data moves in 64-bit chunks; load and combined commands copy first
// R22 - address bits 17:12 sector, 11:7 page, 6:3 double-word, 2:0 byte
// R23 - command word written at offset 0x148; bits 31:24 opcode, rest address
package nvmc_pkg;
  localparam logic [31:0] BANK0_BASE = 32'h6000_0000;
  localparam logic [31:0] BANK1_BASE = 32'h6004_0000;
  localparam int BANK_AW = 18;
  localparam int CTRL_AW = 9;
  localparam logic [8:0] CMD_OFF = 9'h148;
  localparam logic [1:0] STG_REGION = 2'h0;
  localparam logic [1:0] ABUF_REGION = 2'h1;
  localparam int OP_MSB = 31;
  localparam int OP_LSB = 24;
  localparam logic [7:0] OP_SUBMIT = 8'h05;
  localparam logic [7:0] OP_LOAD = 8'h06;
  localparam logic [7:0] OP_BEGIN = 8'h07;
  localparam logic [7:0] OP_COMBINED = 8'h08;
  localparam int PG_MSB = 17;
  localparam int PG_LSB = 7;
  localparam int LINE_LSB = 5;
  localparam int DW_LSB = 3;
  localparam int PAGE_WORDS = 32;
  localparam int PAGE_DWORDS = 16;
  localparam int LINE_DWORDS = 4;
  localparam int SECTOR_PAGES = 32;
  localparam int CLK_MHZ = 100;
  localparam int OSC_MHZ = 25;
  localparam int OSC_DIV = CLK_MHZ / OSC_MHZ;
  localparam int INIT_TICKS_DEF = 16;
  localparam int RD_MIN_CYC = 1;
  localparam logic [2:0] SZ_BYTE = 3'h0;
  localparam logic [2:0] SZ_HALF = 3'h1;
  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_COPY, ST_PROG, ST_COMMIT} nvmc_state_e;
endpackage

// ----------------------------------------
// secded over one 64-bit word
// ----------------------------------------
`timescale 1ns/100ps
module nvmc_secded
  (
  input  logic [63:0] dataIn,
  input  logic [7:0]  chkIn,
  output logic [63:0] dataOut,
  output logic [7:0]  chkOut,
  output logic        corrected,
  output logic        dblErr
  );
  logic [6:0] par;
  logic [6:0] syn;
  logic       ovr;

  // hamming position of data bit i, skipping powers of two
  function automatic logic [6:0] posOf(int i);
    int n;
    n = -1;
    posOf = 7'h00;
    for (int p = 3; p < 72; p++)
      if ((p & (p - 1)) != 0)
      begin
        n = n + 1;
        if (n == i)
          posOf = 7'(p);
      end
  endfunction

  always_comb
  begin
    par = 7'h00;
    for (int i = 0; i < 64; i++)
      for (int k = 0; k < 7; k++)
        if (|(posOf(i) & (7'h01 << k)))
          par[k] = par[k] ^ dataIn[i];
    syn = par ^ chkIn[6:0];
    ovr = (^dataIn) ^ (^chkIn);
    dataOut = dataIn;
    for (int i = 0; i < 64; i++)
      if (ovr && syn == posOf(i))
        dataOut[i] = ~dataIn[i];
    corrected = ovr;
    dblErr = (syn != 7'h00) && !ovr;
    chkOut = {(^dataIn) ^ (^par), par};
  end
endmodule

//--- rtl/nvmc_flash_ctrl.sv
`timescale 1ns/100ps
module nvmc_flash_ctrl
  #(
  parameter int BANK_SEL   = 0,
  parameter int RW_WIDTH   = 4,
  parameter int INIT_TICKS = nvmc_pkg::INIT_TICKS_DEF
  )(
  input  logic                clk,
  input  logic                sys_rst,
  input  logic                hselCtrl,
  input  logic [31:0]         haddr,
  input  logic [1:0]          htrans,
  input  logic                hwrite,
  input  logic [2:0]          hsize,
  input  logic [31:0]         hwdata,
  input  logic                hready,
  output logic                hreadyout,
  output logic                hresp,
  output logic [31:0]         hrdata,
  input  logic [RW_WIDTH-1:0] readWaitRange,
  output logic                arrRdEn,
  output logic [14:0]         arrRdAddr,
  input  logic [63:0]         arrRdData,
  input  logic [7:0]          arrRdChk,
  output logic                arrWrEn,
  output logic [14:0]         arrWrAddr,
  output logic [63:0]         arrWrData,
  output logic [7:0]          arrWrChk,
  output logic                arrCommit,
  input  logic                arrDone,
  input  logic                arrCountExceeded,
  input  logic                clrAccessDenied,
  output logic                busy,
  output logic                accessDenied,
  output logic                pageOverThreshold,
  output logic                eccCorrected,
  output logic                eccDouble
  );
  import nvmc_pkg::*;

  localparam logic [31:0] BASE = (BANK_SEL == 0) ? BANK0_BASE : BANK1_BASE;
  localparam int ICW = $clog2(INIT_TICKS + 1);

  // ----------------------------------------
  // storage and state
  // ----------------------------------------
  logic [31:0]       stg [PAGE_WORDS];
  logic [31:0]       abuf [PAGE_WORDS];
  logic [63:0]       line_q [LINE_DWORDS];
  logic [3:0]        lineOk_q;
  logic              lineValid_q;
  logic [17:5]       tag_q;
  logic              filling_q;
  logic [1:0]        fillDw_q;
  logic [1:0]        fillCnt_q;
  logic [RW_WIDTH:0] waitCnt_q;
  nvmc_state_e       st_q;
  logic [1:0]        oscDiv_q;
  logic              oscTick_q;
  logic [ICW-1:0]    initCnt_q;
  logic [3:0]        copyIdx_q;
  logic [4:0]        progIdx_q;
  logic              startAfter_q;
  logic              addrOk_q;
  logic [17:7]       pageAddr_q;
  logic              errFirst_q;
  logic              rdPend_q;
  logic [17:2]       rdAddr_q;
  logic              dpWr_q;
  logic              dpCtrl_q;
  logic [8:0]        dpAddr_q;
  logic [2:0]        dpSize_q;
  logic [4:0]        wrCnt_q;

  logic              inArray;
  logic              take;
  logic              stIdle;
  logic              hitNow;
  logic              pendHit;
  logic              cmdWr;
  logic              abufDirectWe;
  logic [7:0]        opCode;
  logic [63:0]       fixData;
  logic              fixCorr;
  logic              fixDbl;
  logic [63:0]       progData;
  logic [7:0]        progChk;

  function automatic logic hitFor(logic [17:2] a);
    hitFor = lineValid_q && tag_q == a[17:5] && lineOk_q[a[4:3]];
  endfunction

  function automatic logic [3:0] laneMask(logic [2:0] sz, logic [1:0] a);
    if (sz == SZ_BYTE)
      laneMask = 4'h1 << a;
    else if (sz == SZ_HALF)
      laneMask = a[1] ? 4'hc : 4'h3;
    else
      laneMask = 4'hf;
  endfunction

  assign inArray = haddr[31:BANK_AW] == BASE[31:BANK_AW]; // R01
  assign take = hready && htrans[1] && (inArray || hselCtrl);
  assign stIdle = st_q == ST_IDLE;
  assign hitNow = stIdle && hitFor(haddr[17:2]);
  assign pendHit = stIdle && hitFor(rdAddr_q);
  assign cmdWr = dpWr_q && dpCtrl_q && dpAddr_q == CMD_OFF; // R23
  assign abufDirectWe = dpWr_q && dpCtrl_q && dpAddr_q[8:7] == ABUF_REGION && stIdle; // R10
  assign opCode = hwdata[OP_MSB:OP_LSB];

  // ----------------------------------------
  // ecc on both array paths
  // ----------------------------------------
  nvmc_secded u_rdFix
  (
    .dataIn    (arrRdData),
    .chkIn     (arrRdChk),
    .dataOut   (fixData),
    .chkOut    (),
    .corrected (fixCorr),
    .dblErr    (fixDbl)
  );

  assign progData = {abuf[{progIdx_q[3:0], 1'b1}], abuf[{progIdx_q[3:0], 1'b0}]}; // R15
  nvmc_secded u_wrEnc
  (
    .dataIn    (progData),
    .chkIn     (8'h00),
    .dataOut   (),
    .chkOut    (progChk),
    .corrected (),
    .dblErr    ()
  );

  // ----------------------------------------
  // oscillator pace, 25 MHz from bus clock
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      oscDiv_q <= 2'h0;
      oscTick_q <= 1'b0;
    end
    else
    begin
      oscDiv_q <= (oscDiv_q == 2'(OSC_DIV - 1)) ? 2'h0 : oscDiv_q + 2'h1;
      oscTick_q <= oscDiv_q == 2'(OSC_DIV - 1); // R02
    end

  // ----------------------------------------
  // bus slave response
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0;
      errFirst_q <= 1'b0;
      rdPend_q <= 1'b0;
      rdAddr_q <= '0;
      dpWr_q <= 1'b0;
      dpCtrl_q <= 1'b0;
      dpAddr_q <= 9'h0;
      dpSize_q <= 3'h0;
    end
    else if (errFirst_q)
    begin
      hreadyout <= 1'b1;
      errFirst_q <= 1'b0;
    end
    else if (rdPend_q)
    begin
      if (pendHit)
      begin
        hrdata <= rdAddr_q[2] ? line_q[rdAddr_q[4:3]][63:32]
                              : line_q[rdAddr_q[4:3]][31:0]; // R07
        hreadyout <= 1'b1;
        rdPend_q <= 1'b0;
      end
    end
    else
    begin
      hresp <= 1'b0;
      dpWr_q <= take && hwrite && !inArray;
      dpCtrl_q <= take && !inArray;
      dpAddr_q <= haddr[CTRL_AW-1:0];
      dpSize_q <= hsize;
      if (take && inArray && hwrite)
      begin
        hreadyout <= 1'b0; // R17
        hresp <= 1'b1;
        errFirst_q <= 1'b1;
      end
      else if (take && inArray)
      begin
        if (hitNow)
          hrdata <= haddr[2] ? line_q[haddr[4:3]][63:32] : line_q[haddr[4:3]][31:0]; // R08
        else
        begin
          hreadyout <= 1'b0; // R08
          rdPend_q <= 1'b1;
          rdAddr_q <= haddr[17:2];
        end
      end
      else if (take && !hwrite && haddr[8:7] == ABUF_REGION)
        hrdata <= abuf[haddr[6:2]]; // R16
      else if (take)
        hrdata <= 32'h0;
    end

  // ----------------------------------------
  // read line fill
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      filling_q <= 1'b0;
      lineValid_q <= 1'b0;
      lineOk_q <= 4'h0;
      tag_q <= '0;
      fillDw_q <= 2'h0;
      fillCnt_q <= 2'h0;
      waitCnt_q <= '0;
      arrRdEn <= 1'b0;
      arrRdAddr <= 15'h0;
      eccCorrected <= 1'b0;
      eccDouble <= 1'b0;
    end
    else
    begin
      arrRdEn <= 1'b0;
      eccCorrected <= 1'b0;
      eccDouble <= 1'b0;
      if (st_q == ST_COMMIT && arrDone)
        lineValid_q <= 1'b0;
      else if (!filling_q)
      begin
        if (rdPend_q && stIdle && !(lineValid_q && tag_q == rdAddr_q[17:5]))
        begin
          filling_q <= 1'b1; // R06
          lineValid_q <= 1'b1;
          lineOk_q <= 4'h0;
          tag_q <= rdAddr_q[17:5];
          fillDw_q <= rdAddr_q[4:3];
          fillCnt_q <= 2'h0;
          arrRdEn <= 1'b1;
          arrRdAddr <= rdAddr_q[17:3]; // R22
          waitCnt_q <= (RW_WIDTH + 1)'(readWaitRange) + (RW_WIDTH + 1)'(RD_MIN_CYC); // R04
        end
      end
      else if (waitCnt_q != '0)
        waitCnt_q <= waitCnt_q - 1'b1; // R03
      else
      begin
        line_q[fillDw_q] <= fixData; // R05
        lineOk_q[fillDw_q] <= 1'b1;
        eccCorrected <= fixCorr;
        eccDouble <= fixDbl;
        fillCnt_q <= fillCnt_q + 2'h1;
        if (fillCnt_q == 2'(LINE_DWORDS - 1))
          filling_q <= 1'b0;
        else
        begin
          fillDw_q <= fillDw_q + 2'h1; // R07
          arrRdEn <= 1'b1;
          arrRdAddr <= {tag_q, fillDw_q + 2'h1};
          waitCnt_q <= (RW_WIDTH + 1)'(readWaitRange) + (RW_WIDTH + 1)'(RD_MIN_CYC); // R04
        end
      end
    end

  // ----------------------------------------
  // staging and assembly buffers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (dpWr_q && dpCtrl_q && dpAddr_q[8:7] == STG_REGION)
      for (int b = 0; b < 4; b++)
        if (|(laneMask(dpSize_q, dpAddr_q[1:0]) & (4'h1 << b)))
          stg[dpAddr_q[6:2]][8*b +: 8] <= hwdata[8*b +: 8]; // R18 R12
    if (st_q == ST_COPY)
    begin
      abuf[{copyIdx_q, 1'b0}] <= stg[{copyIdx_q, 1'b0}]; // R21
      abuf[{copyIdx_q, 1'b1}] <= stg[{copyIdx_q, 1'b1}];
    end
    else if (abufDirectWe)
      abuf[dpAddr_q[6:2]] <= hwdata; // R19
  end

  // ----------------------------------------
  // command and program sequence
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      st_q <= ST_INIT;
      initCnt_q <= '0;
      copyIdx_q <= 4'h0;
      progIdx_q <= 5'h0;
      startAfter_q <= 1'b0;
      addrOk_q <= 1'b0;
      pageAddr_q <= '0;
      arrWrEn <= 1'b0;
      arrWrAddr <= 15'h0;
      arrWrData <= 64'h0;
      arrWrChk <= 8'h0;
      arrCommit <= 1'b0;
    end
    else
    begin
      arrWrEn <= 1'b0;
      arrCommit <= 1'b0;
      case (st_q)
        ST_INIT:
          if (oscTick_q)
          begin
            initCnt_q <= initCnt_q + 1'b1; // R02
            if (initCnt_q == ICW'(INIT_TICKS - 1))
              st_q <= ST_IDLE;
          end
        ST_IDLE:
          if (cmdWr && !accessDenied)
          begin
            copyIdx_q <= 4'h0;
            progIdx_q <= 5'h0;
            if (opCode == OP_SUBMIT)
            begin
              pageAddr_q <= hwdata[PG_MSB:PG_LSB]; // R20
              addrOk_q <= 1'b1;
            end
            else if (opCode == OP_LOAD && addrOk_q)
            begin
              st_q <= ST_COPY;
              startAfter_q <= 1'b0;
            end
            else if (opCode == OP_BEGIN && addrOk_q)
              st_q <= ST_PROG; // R19
            else if (opCode == OP_COMBINED)
            begin
              pageAddr_q <= hwdata[PG_MSB:PG_LSB];
              addrOk_q <= 1'b1;
              st_q <= ST_COPY; // R21
              startAfter_q <= 1'b1;
            end
          end
        ST_COPY:
        begin
          copyIdx_q <= copyIdx_q + 4'h1;
          if (copyIdx_q == 4'(PAGE_DWORDS - 1))
            st_q <= startAfter_q ? ST_PROG : ST_IDLE;
        end
        ST_PROG:
          if (oscTick_q)
          begin
            if (progIdx_q == 5'(PAGE_DWORDS))
            begin
              arrCommit <= 1'b1; // R09
              st_q <= ST_COMMIT;
            end
            else
            begin
              arrWrEn <= 1'b1; // R02
              arrWrAddr <= {pageAddr_q, progIdx_q[3:0]}; // R13 R20
              arrWrData <= progData;
              arrWrChk <= progChk; // R05
              progIdx_q <= progIdx_q + 5'h1;
            end
          end
        ST_COMMIT:
          if (arrDone)
          begin
            st_q <= ST_IDLE;
            addrOk_q <= 1'b0; // R11
          end
        default:
          st_q <= ST_IDLE;
      endcase
    end

  // ----------------------------------------
  // status flags
  // ----------------------------------------
  always_ff @(posedge clk or posedge sys_rst)
    if (sys_rst)
    begin
      busy <= 1'b1;
      accessDenied <= 1'b0;
      pageOverThreshold <= 1'b0;
      wrCnt_q <= 5'h0;
    end
    else
    begin
      busy <= !stIdle;
      if (cmdWr && !stIdle)
        accessDenied <= 1'b1; // R23
      else if (clrAccessDenied)
        accessDenied <= 1'b0;
      if (st_q == ST_COMMIT && arrCountExceeded)
        pageOverThreshold <= 1'b1; // R14
      else if (st_q == ST_IDLE && cmdWr && !accessDenied && opCode == OP_COMBINED)
        pageOverThreshold <= 1'b0;
      if (st_q == ST_IDLE)
        wrCnt_q <= 5'h0;
      else if (arrWrEn)
        wrCnt_q <= wrCnt_q + 5'h1;
    end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence errPair;
    (!hreadyout && hresp) ##1 (hreadyout && hresp);
  endsequence

  sequence rdArrive;
    take && inArray && !hwrite;
  endsequence

  a_array_write_err: assert property (@(posedge clk) disable iff (sys_rst) // R17
    take && inArray && hwrite && !errFirst_q && !rdPend_q |=> errPair)
    else $error("array write not answered with two-cycle error");

  a_hit_zero_wait: assert property (@(posedge clk) disable iff (sys_rst) // R08
    rdArrive and hitNow && !errFirst_q && !rdPend_q |=> hreadyout && !hresp)
    else $error("buffered read did not return at once");

  a_miss_stall: assert property (@(posedge clk) disable iff (sys_rst) // R08
    rdArrive and !hitNow && !errFirst_q && !rdPend_q && !filling_q |=> !hreadyout ##1 !hreadyout)
    else $error("read miss did not stall");

  a_abuf_frozen: assert property (@(posedge clk) disable iff (sys_rst) // R10
    st_q == ST_PROG || st_q == ST_COMMIT |=> $stable(abuf[0]))
    else $error("assembly buffer written during programming");

  a_osc_pace: assert property (@(posedge clk) disable iff (sys_rst) // R02
    arrWrEn |-> !$past(arrWrEn) && $past(oscTick_q))
    else $error("array write not on oscillator pace");

  a_whole_page: assert property (@(posedge clk) disable iff (sys_rst) // R09
    arrCommit |-> wrCnt_q == 5'(PAGE_DWORDS))
    else $error("commit without a whole page written");

  a_copy_chunks: assert property (@(posedge clk) disable iff (sys_rst) // R21
    $fell(st_q == ST_COPY) |-> $past(copyIdx_q) == 4'(PAGE_DWORDS - 1))
    else $error("copy did not move sixteen double-words");

  a_deny_busy: assert property (@(posedge clk) disable iff (sys_rst) // R23
    cmdWr && !stIdle && !clrAccessDenied |=> accessDenied [*2])
    else $error("command while busy not denied");

  a_wait_count: assert property (@(posedge clk) disable iff (sys_rst) // R04
    arrRdEn |-> waitCnt_q == (RW_WIDTH + 1)'(readWaitRange) + (RW_WIDTH + 1)'(RD_MIN_CYC))
    else $error("wait states not loaded from read wait range");
endmodule

//--- tb/nvmc_array_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// array model behind the controller
// ----------------------------------------
module nvmc_array_model
  (
  input  logic        clk,
  input  logic [3:0]  readWaitRange,
  input  logic        arrRdEn,
  input  logic [14:0] arrRdAddr,
  output logic [63:0] arrRdData,
  output logic [7:0]  arrRdChk,
  input  logic        arrWrEn,
  input  logic [14:0] arrWrAddr,
  input  logic [63:0] arrWrData,
  input  logic [7:0]  arrWrChk,
  input  logic        arrCommit,
  output logic        arrDone,
  input  logic [7:0]  doneDelay,
  input  logic        flipBit
  );
  logic [71:0] memQ [logic [14:0]];
  logic [71:0] pendQ [logic [14:0]];
  logic [71:0] dataQ = 72'h0;
  logic [7:0]  ageQ  = 8'hff;
  logic [7:0]  cntQ  = 8'h0;
  logic        progQ = 1'b0;
  logic        okRd;

  assign okRd = ageQ >= {4'h0, readWaitRange};
  // unsettled data is inverted and shifts every cycle
  assign arrRdData = okRd ? dataQ[63:0] ^ {58'h0, flipBit, 5'h0} : ~dataQ[63:0] ^ {8{ageQ}};
  assign arrRdChk  = okRd ? dataQ[71:64] : ~dataQ[71:64] ^ ageQ;

  always @(posedge clk)
  begin
    if (arrWrEn)
      pendQ[arrWrAddr] = {arrWrChk, arrWrData};
    if (arrCommit)
    begin
      foreach (pendQ[a])
        memQ[a] = pendQ[a];
      pendQ.delete();
    end
    if (arrRdEn)
    begin
      dataQ <= memQ.exists(arrRdAddr) ? memQ[arrRdAddr] : 72'h0;
      ageQ  <= 8'h0;
    end
    else if (ageQ != 8'hff)
      ageQ <= ageQ + 8'h1;
    arrDone <= progQ && cntQ == 8'h0 && !arrCommit;
    if (arrCommit)
    begin
      progQ <= 1'b1;
      cntQ  <= doneDelay;
    end
    else if (progQ && cntQ == 8'h0)
      progQ <= 1'b0;
    else if (progQ)
      cntQ <= cntQ - 8'h1;
  end
endmodule

//--- tb/nvmc_flash_ctrl_tb_top.sv
`timescale 1ns/100ps
// ----------------------------------------
// controller bench
// ----------------------------------------
module nvmc_flash_ctrl_tb_top;
  import nvmc_pkg::*;
  localparam int LIMIT = 60000;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hselCtrl = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0]  readWaitRange = 4'h3;
  logic        arrCountExceeded = 1'b0;
  logic        clrAccessDenied = 1'b0;
  logic [7:0]  doneDelay = 8'h4;
  logic        flipBit = 1'b0;
  logic        hreadyout, hresp, busy, accessDenied, pageOverThreshold, eccCorrected, eccDouble;
  logic        arrRdEn, arrWrEn, arrCommit, arrDone, rspV;
  logic [31:0] hrdata, rdV;
  logic [14:0] arrRdAddr, arrWrAddr;
  logic [63:0] arrRdData, arrWrData;
  logic [7:0]  arrRdChk, arrWrChk;
  logic [15:0] wrMask;
  logic [10:0] expPage;
  int          waitN, errors, checked, cycles, wrCnt, wrBad, commitCnt, eccCnt;

  always #5 clk = ~clk;

  nvmc_flash_ctrl #(.BANK_SEL(0), .RW_WIDTH(4), .INIT_TICKS(2)) nvmc_flash_ctrl_inst (
    .clk(clk), .sys_rst(sys_rst), .hselCtrl(hselCtrl), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .readWaitRange(readWaitRange),
    .arrRdEn(arrRdEn), .arrRdAddr(arrRdAddr), .arrRdData(arrRdData), .arrRdChk(arrRdChk),
    .arrWrEn(arrWrEn), .arrWrAddr(arrWrAddr), .arrWrData(arrWrData), .arrWrChk(arrWrChk),
    .arrCommit(arrCommit), .arrDone(arrDone), .arrCountExceeded(arrCountExceeded),
    .clrAccessDenied(clrAccessDenied), .busy(busy), .accessDenied(accessDenied),
    .pageOverThreshold(pageOverThreshold), .eccCorrected(eccCorrected), .eccDouble(eccDouble));

  nvmc_array_model nvmc_array_model_inst (
    .clk(clk), .readWaitRange(readWaitRange), .arrRdEn(arrRdEn), .arrRdAddr(arrRdAddr),
    .arrRdData(arrRdData), .arrRdChk(arrRdChk), .arrWrEn(arrWrEn), .arrWrAddr(arrWrAddr),
    .arrWrData(arrWrData), .arrWrChk(arrWrChk), .arrCommit(arrCommit), .arrDone(arrDone),
    .doneDelay(doneDelay), .flipBit(flipBit));

  always @(posedge clk)
  begin
    if (arrWrEn === 1'b1)
    begin
      wrCnt++;
      wrMask[arrWrAddr[3:0]] = 1'b1;
      if (arrWrAddr[14:4] !== expPage)
        wrBad++;
    end
    if (arrCommit === 1'b1)
      commitCnt++;
    if (eccCorrected === 1'b1)
      eccCnt++;
    if (eccDouble === 1'b1)
      eccCnt += 64;
    cycles++;
    if (cycles == LIMIT)
    begin
      errors++;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] pat(input logic [10:0] pg, input int i, input logic [7:0] s);
    return {s, 5'h0, pg, 8'(i)};
  endfunction

  task automatic xfer(input logic sel, input logic wr, input logic [31:0] a,
                      input logic [2:0] sz, input logic [31:0] d);
    waitN = 0;
    @(posedge clk);
    hselCtrl <= sel;
    haddr    <= a;
    htrans   <= 2'h2;
    hwrite   <= wr;
    hsize    <= sz;
    @(posedge clk);
    hselCtrl <= 1'b0;
    htrans   <= 2'h0;
    hwdata   <= d;
    do
    begin
      @(posedge clk);
      waitN++;
    end
    while (hreadyout !== 1'b1 && waitN < 3000);
    rdV  = hrdata;
    rspV = hresp;
  endtask

  task automatic arr(input logic wr, input logic [31:0] a, input logic [31:0] d);
    xfer(1'b0, wr, a, 3'h2, d);
  endtask

  task automatic ctl(input logic wr, input logic [8:0] off, input logic [31:0] d,
                     input logic [2:0] sz);
    xfer(1'b1, wr, {23'h0, off}, sz, d);
  endtask

  task automatic cmd(input logic [7:0] op, input logic [10:0] pg);
    ctl(1'b1, CMD_OFF, {op, 6'h0, pg, 7'h0}, 3'h2);
  endtask

  task automatic waitIdle;
    int n;
    n = 0;
    repeat (3) @(posedge clk);
    while (busy !== 1'b0 && n < 5000)
    begin
      @(posedge clk);
      n++;
    end
  endtask

  task automatic fillStage(input logic [10:0] pg, input logic [7:0] s);
    int i;
    int k;
    for (i = 0; i < 32; i++)
      case (i % 3)
        0: ctl(1'b1, 9'(i * 4), pat(pg, i, s), 3'h2);
        1: for (k = 0; k < 4; k += 2) ctl(1'b1, 9'(i * 4 + k), pat(pg, i, s), SZ_HALF);
        default: for (k = 0; k < 4; k++) ctl(1'b1, 9'(i * 4 + k), pat(pg, i, s), SZ_BYTE);
      endcase
  endtask

  task automatic readPage(input logic [10:0] pg, input logic [10:0] dpg, input logic [7:0] s);
    int i;
    for (i = 0; i < 32; i++)
    begin
      arr(1'b0, BANK0_BASE + 32'({pg, 7'h0}) + 32'(i * 4), 32'h0);
      check(rdV, pat(dpg, i, s));
    end
  endtask

  task automatic monStart(input logic [10:0] pg);
    wrCnt = 0;
    wrBad = 0;
    commitCnt = 0;
    wrMask = 16'h0;
    expPage = pg;
  endtask

  task automatic progCheck;
    check(wrCnt, 32'h10);
    check(wrMask, 16'hffff);
    check(wrBad, 32'h0);
    check(commitCnt, 32'h1);
  endtask

  task automatic t_init;
    int n;
    n = 0;
    check(busy, 1'b1);
    while (busy !== 1'b0 && n < 100)
    begin
      @(posedge clk);
      n++;
    end
    check(n >= 6 && n <= 14, 1'b1);
    $display("done: init");
  endtask

  task automatic t_program;
    fillStage(11'h005, 8'ha1);
    monStart(11'h005);
    cmd(OP_COMBINED, 11'h005);
    waitIdle();
    progCheck();
    readPage(11'h005, 11'h005, 8'ha1);
    $display("done: program");
  endtask

  task automatic t_timing;
    int j;
    int k;
    logic [3:0] rw;
    logic [31:0] base;
    for (j = 0; j < 2; j++)
    begin
      rw = j ? 4'h1 : 4'h5;
      base = BANK0_BASE + 32'h2a0 + 32'(j * 32);
      readWaitRange <= rw;
      arr(1'b0, base, 32'h0);
      check(waitN >= rw + 3 && waitN <= rw + 6, 1'b1);
      check(rdV, pat(11'h005, 8 + j * 8, 8'ha1));
      arr(1'b0, base + 32'h4, 32'h0);
      check(waitN, 32'h1);
      for (k = 2; k < 8; k++)
      begin
        arr(1'b0, base + 32'(k * 4), 32'h0);
        check(rdV, pat(11'h005, 8 + j * 8 + k, 8'ha1));
      end
      arr(1'b0, base + 32'h18, 32'h0);
      check(waitN, 32'h1);
    end
    $display("done: timing");
  endtask

  task automatic t_write_err;
    arr(1'b1, BANK0_BASE + 32'h280, 32'hdead_beef);
    check(rspV, 1'b1);
    arr(1'b0, BANK0_BASE + 32'h280, 32'h0);
    check(rdV, pat(11'h005, 0, 8'ha1));
    check(rspV, 1'b0);
    $display("done: write error");
  endtask

  task automatic t_abuf;
    int i;
    for (i = 0; i < 32; i++)
      ctl(1'b1, 9'h080 + 9'(i * 4), pat(11'h006, i, 8'hb2), 3'h2);
    for (i = 0; i < 32; i += 5)
    begin
      ctl(1'b0, 9'h080 + 9'(i * 4), 32'h0, 3'h2);
      check(rdV, pat(11'h006, i, 8'hb2));
    end
    doneDelay <= 8'hc8;
    cmd(OP_SUBMIT, 11'h006);
    waitIdle();
    monStart(11'h006);
    cmd(OP_BEGIN, 11'h006);
    ctl(1'b1, 9'h080, 32'h0, 3'h2);
    check(busy, 1'b1);
    fillStage(11'h007, 8'hc3);
    waitIdle();
    ctl(1'b0, 9'h080, 32'h0, 3'h2);
    check(rdV, pat(11'h006, 0, 8'hb2));
    progCheck();
    readPage(11'h006, 11'h006, 8'hb2);
    doneDelay <= 8'h4;
    cmd(OP_COMBINED, 11'h007);
    waitIdle();
    readPage(11'h007, 11'h007, 8'hc3);
    $display("done: assembly buffer");
  endtask

  task automatic t_denied;
    arrCountExceeded <= 1'b1;
    doneDelay <= 8'h28;
    monStart(11'h008);
    cmd(OP_COMBINED, 11'h008);
    cmd(OP_SUBMIT, 11'h009);
    waitIdle();
    check(accessDenied, 1'b1);
    check(pageOverThreshold, 1'b1);
    progCheck();
    readPage(11'h008, 11'h007, 8'hc3);
    cmd(OP_COMBINED, 11'h009);
    repeat (4) @(posedge clk);
    check(busy, 1'b0);
    clrAccessDenied <= 1'b1;
    arrCountExceeded <= 1'b0;
    @(posedge clk);
    clrAccessDenied <= 1'b0;
    repeat (2) @(posedge clk);
    check(accessDenied, 1'b0);
    $display("done: denied");
  endtask

  task automatic t_ecc;
    flipBit <= 1'b1;
    eccCnt = 0;
    arr(1'b0, BANK0_BASE + 32'h388, 32'h0);
    check(rdV, pat(11'h007, 2, 8'hc3));
    check(eccCnt > 0 && eccCnt < 64, 1'b1);
    flipBit <= 1'b0;
    $display("done: correction");
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_init();
    t_program();
    t_timing();
    t_write_err();
    t_abuf();
    t_denied();
    t_ecc();
    end_of_test();
  end
endmodule
